// ===== pkg/qpfe_pkg.sv
// constants and types for the quad phase fetch/execute pipeline
// Behaviour
// - oscillator divided by four into four non-overlapping phases forming one instruction cycle
// - program counter increments once per instruction cycle, in phase_one, except in the no-operation slot after a branch or after reset
// - addressed instruction word is read and latched in phase_four of fetch
// - fetch of next instruction overlaps execution of current one
// - instruction register loads fetched word at phase_one; execute over phases two to four
// - data memory operand read in phase_two, destination write in phase_four
// - program counter changing instructions take two cycles, others one
// - on branch the prefetched word is discarded and a no-operation fills its slot
// - instruction rate clock output at one quarter of oscillator frequency
package qpfe_pkg;
   localparam int unsigned PC_W_DEF   = 13;
   localparam int unsigned INSTR_W    = 14;
   localparam int unsigned PHASES     = 4;
   localparam logic [13:0] NOP_WORD   = 14'h0000;
   localparam logic [12:0] RESET_PC   = 13'h0000;

   // phase counter codes, binary
   typedef enum logic [1:0] {
      QPFE_PH_ONE   = 2'b00,
      QPFE_PH_TWO   = 2'b01,
      QPFE_PH_THREE = 2'b10,
      QPFE_PH_FOUR  = 2'b11
   } qpfe_phase_e;
endpackage : qpfe_pkg

// ===== rtl/qpfe_phase_gen.sv
// four phase generator dividing the oscillator clock by four
`timescale 1ns/1ps
`default_nettype none
module qpfe_phase_gen (
   input  wire logic                 CLK,
   input  wire logic                 RST_N,
   input  wire logic                 CE,
   output var  qpfe_pkg::qpfe_phase_e phase,
   output logic                      clk_out_next
);
   import qpfe_pkg::*;

   qpfe_phase_e phase_reg;
   assign phase = phase_reg;

   // cyclic advance; reset lands in phase one
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         phase_reg <= QPFE_PH_ONE;
      end else if (CE) begin
         unique case (phase_reg)
            QPFE_PH_ONE:   phase_reg <= QPFE_PH_TWO;
            QPFE_PH_TWO:   phase_reg <= QPFE_PH_THREE;
            QPFE_PH_THREE: phase_reg <= QPFE_PH_FOUR;
            QPFE_PH_FOUR:  phase_reg <= QPFE_PH_ONE;
         endcase
      end
   end

   // clock out high in phases one and two, giving 50 % duty at osc/4
   assign clk_out_next = CE ? (phase_reg == QPFE_PH_FOUR || phase_reg == QPFE_PH_ONE)
                            : (phase_reg == QPFE_PH_ONE || phase_reg == QPFE_PH_TWO);

   a_phase_cycle: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase_reg == QPFE_PH_FOUR |=> phase_reg == QPFE_PH_ONE)
      else $error("phase four not followed by phase one");
endmodule : qpfe_phase_gen
`default_nettype wire

// ===== rtl/qpfe_pipeline.sv
// two stage fetch/execute sequencer with phase outputs
`timescale 1ns/1ps
`default_nettype none
module qpfe_pipeline #(
   parameter int unsigned PC_W = qpfe_pkg::PC_W_DEF
) (
   input  wire logic                        CLK,
   input  wire logic                        RST_N,
   input  wire logic                        CE,
   input  wire logic [qpfe_pkg::INSTR_W-1:0] PROG_DATA,
   input  wire logic                        BRANCH_TAKEN,
   input  wire logic [PC_W-1:0]             BRANCH_TARGET,
   output logic      [PC_W-1:0]             PROG_ADDR,
   output logic      [qpfe_pkg::INSTR_W-1:0] INSTR_REG,
   output logic                             EXEC_VALID,
   output logic                             PHASE_ONE,
   output logic                             PHASE_TWO,
   output logic                             PHASE_THREE,
   output logic                             PHASE_FOUR,
   output logic                             DATA_RD,
   output logic                             DATA_WR,
   output logic                             INSTR_RATE_CLOCK_OUT
);
   import qpfe_pkg::*;

   qpfe_phase_e            phase;
   logic                   clk_out_next;
   logic [PC_W-1:0]        pc_reg;
   logic [INSTR_W-1:0]     fetch_reg;
   logic [INSTR_W-1:0]     ir_reg;
   logic                   exec_valid_reg;
   logic                   exec_valid_next;
   logic                   flush_reg;
   logic [3:0]             ph_reg;
   logic                   rd_reg;
   logic                   wr_reg;
   logic                   ck_reg;
   qpfe_phase_e            ph_next;

   qpfe_phase_gen u_phase (
      .CLK          (CLK),
      .RST_N        (RST_N),
      .CE           (CE),
      .phase        (phase),
      .clk_out_next (clk_out_next)
   );

   // phase the registered outputs will show on the next edge
   function automatic qpfe_phase_e step(input qpfe_phase_e p);
      step = qpfe_phase_e'(p + 2'b01);
   endfunction : step

   assign ph_next = CE ? step(phase) : phase;

   // true on an enabled edge that leaves phase p; all inputs passed so continuous users re-evaluate
   function automatic logic leaving(input logic en, input qpfe_phase_e now, input qpfe_phase_e p);
      leaving = en && (now == p);
   endfunction : leaving

   // execute-stage valid as it will stand after this edge
   assign exec_valid_next = leaving(CE, phase, QPFE_PH_ONE) ? !flush_reg : exec_valid_reg;

   // one-hot phase outputs, registered in step with the counter
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ph_reg <= 4'h1;
      end else if (CE) begin
         ph_reg <= 4'h1 << ph_next;
      end
   end

   // strobes follow the slot about to execute, so a flushed slot stays quiet
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
      end else if (CE) begin
         rd_reg <= (ph_next == QPFE_PH_TWO) && exec_valid_next;
         wr_reg <= (ph_next == QPFE_PH_FOUR) && exec_valid_next;
      end
   end

   // clock out registered so it leaves the block glitch-free
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ck_reg <= 1'b1;
      end else if (CE) begin
         ck_reg <= clk_out_next;
      end
   end

   // program counter: increments at phase one, or loads target after a branch;
   // no increment in a flushed slot, else the target word itself would be skipped
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pc_reg <= RESET_PC[PC_W-1:0];
      end else if (leaving(CE, phase, QPFE_PH_FOUR) && BRANCH_TAKEN && exec_valid_reg) begin
         pc_reg <= BRANCH_TARGET;
      end else if (leaving(CE, phase, QPFE_PH_ONE) && !flush_reg) begin
         pc_reg <= pc_reg + 1'b1;
      end
   end

   // fetch latch in phase four; the word fetched during a branch is marked stale
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         fetch_reg <= NOP_WORD;
         flush_reg <= 1'b1;
      end else if (CE && phase == QPFE_PH_FOUR) begin
         fetch_reg <= PROG_DATA;
         flush_reg <= BRANCH_TAKEN && exec_valid_reg;
      end
   end

   // execute stage loads at phase one; flushed slot becomes a no-op
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ir_reg         <= NOP_WORD;
         exec_valid_reg <= 1'b0;
      end else if (CE && phase == QPFE_PH_ONE) begin
         ir_reg         <= flush_reg ? NOP_WORD : fetch_reg;
         exec_valid_reg <= !flush_reg;
      end
   end

   assign PROG_ADDR            = pc_reg;
   assign INSTR_REG            = ir_reg;
   assign EXEC_VALID           = exec_valid_reg;
   assign PHASE_ONE            = ph_reg[0];
   assign PHASE_TWO            = ph_reg[1];
   assign PHASE_THREE          = ph_reg[2];
   assign PHASE_FOUR           = ph_reg[3];
   assign DATA_RD              = rd_reg;
   assign DATA_WR              = wr_reg;
   assign INSTR_RATE_CLOCK_OUT = ck_reg;

   a_phase_onehot: assert property (@(posedge CLK) disable iff (!RST_N)
      $onehot(ph_reg))
      else $error("phase outputs not one-hot");

   a_phase_order: assert property (@(posedge CLK) disable iff (!RST_N)
      RST_N && CE && PHASE_ONE ##1 CE |=> PHASE_THREE)
      else $error("phase three not two steps after phase one");

   a_pc_inc: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase == QPFE_PH_ONE && !flush_reg |=> pc_reg == PC_W'($past(pc_reg) + 1'b1))
      else $error("pc did not increment in phase one");

   a_pc_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (phase == QPFE_PH_TWO || phase == QPFE_PH_THREE) |=> $stable(pc_reg))
      else $error("pc moved outside phase one");

   a_fetch_latch: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase == QPFE_PH_FOUR |=> fetch_reg == $past(PROG_DATA))
      else $error("fetch word not latched in phase four");

   a_ir_load: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase == QPFE_PH_ONE && !flush_reg |=> ir_reg == $past(fetch_reg) && exec_valid_reg)
      else $error("instruction register not loaded in phase one");

   a_rd_phase: assert property (@(posedge CLK) disable iff (!RST_N)
      DATA_RD |-> PHASE_TWO && !DATA_WR)
      else $error("data read outside phase two");

   a_wr_phase: assert property (@(posedge CLK) disable iff (!RST_N)
      DATA_WR |-> PHASE_FOUR)
      else $error("data write outside phase four");

   a_branch_flush: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase == QPFE_PH_FOUR && BRANCH_TAKEN && exec_valid_reg
      |=> flush_reg && pc_reg == $past(BRANCH_TARGET))
      else $error("branch did not flush or load target");

   a_nop_slot: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase == QPFE_PH_ONE && flush_reg |=> !exec_valid_reg && ir_reg == NOP_WORD)
      else $error("flushed slot not a no-op");

   a_clk_out: assert property (@(posedge CLK) disable iff (!RST_N)
      PHASE_ONE |-> INSTR_RATE_CLOCK_OUT)
      else $error("instruction clock low in phase one");

   a_clk_high: assert property (@(posedge CLK) disable iff (!RST_N)
      PHASE_TWO |-> INSTR_RATE_CLOCK_OUT)
      else $error("instruction clock low in phase two");

   a_clk_low: assert property (@(posedge CLK) disable iff (!RST_N)
      PHASE_THREE || PHASE_FOUR |-> !INSTR_RATE_CLOCK_OUT)
      else $error("instruction clock high in second half");

   a_rd_valid: assert property (@(posedge CLK) disable iff (!RST_N)
      DATA_RD |-> EXEC_VALID)
      else $error("data read in a flushed slot");

   a_wr_valid: assert property (@(posedge CLK) disable iff (!RST_N)
      DATA_WR |-> EXEC_VALID)
      else $error("data write in a flushed slot");

   a_rd_issue: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase == QPFE_PH_ONE && !flush_reg |=> DATA_RD)
      else $error("no operand read for a valid instruction");

   a_wr_issue: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase == QPFE_PH_THREE && exec_valid_reg |=> DATA_WR)
      else $error("no destination write for a valid instruction");

   a_ir_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      phase != QPFE_PH_ONE |=> $stable(ir_reg))
      else $error("instruction register moved outside phase one");

   a_fetch_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      phase != QPFE_PH_FOUR |=> $stable(fetch_reg))
      else $error("fetch latch moved outside phase four");

   a_slot_pc: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase == QPFE_PH_ONE && flush_reg |=> $stable(pc_reg))
      else $error("pc stepped past the branch target");

   a_slot_fetch: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && phase == QPFE_PH_FOUR && flush_reg |=> !flush_reg)
      else $error("flush carried past the target fetch");

   a_ce_freeze: assert property (@(posedge CLK) disable iff (!RST_N)
      !CE |=> $stable(ph_reg) && $stable(pc_reg) && $stable(ir_reg) && $stable(ck_reg))
      else $error("state moved while clock enable low");
endmodule : qpfe_pipeline
`default_nettype wire

// ===== testbench/qpfe_prog_mem.sv
// program memory model answering every address with a marked word
`timescale 1ns/1ps
`default_nettype none
module qpfe_prog_mem #(
   parameter int unsigned AW = 13
) (
   input  wire logic [AW-1:0] ADDR,
   output logic      [13:0]   DATA
);
   // top bit set so a flushed no-op slot never looks like a real word
   assign DATA = 14'h2000 | 14'(ADDR);
endmodule : qpfe_prog_mem
`default_nettype wire

// ===== testbench/quad_phase_fetch_execute_pipeline_test.sv
// self-checking bench for the fetch/execute sequencer
`timescale 1ns/1ps
`default_nettype none
module quad_phase_fetch_execute_pipeline_test;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic        br = 1'b0;
   logic [12:0] tgt = 13'h0000;
   logic [12:0] addr;
   logic [13:0] pdata;
   logic [13:0] ir;
   logic        valid, p1, p2, p3, p4, rd, wr, cko;
   logic [12:0] last;
   int          errors = 0;
   int          checked = 0;
   qpfe_prog_mem MEM (.ADDR(addr), .DATA(pdata));
   qpfe_pipeline DUT (.CLK(clk), .RST_N(rst_n), .CE(ce), .PROG_DATA(pdata), .BRANCH_TAKEN(br),
      .BRANCH_TARGET(tgt), .PROG_ADDR(addr), .INSTR_REG(ir), .EXEC_VALID(valid), .PHASE_ONE(p1),
      .PHASE_TWO(p2), .PHASE_THREE(p3), .PHASE_FOUR(p4), .DATA_RD(rd), .DATA_WR(wr),
      .INSTR_RATE_CLOCK_OUT(cko));
   // 50 ns period
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   // settle on the falling edge where phase n is shown, bounded
   task automatic to_phase(input int n);
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         if ({p4, p3, p2, p1} === 4'(1 << n)) break;
      end
      if ({p4, p3, p2, p1} !== 4'(1 << n)) begin
         errors++;
         $display("unexpected phase wait: expected %0d, seen %b", n, {p4, p3, p2, p1});
      end
   endtask : to_phase
   task automatic test_reset();
      repeat (10) @(negedge clk);
      chk("phases", 14'h1, 14'({p4, p3, p2, p1}));
      chk("pc", 14'h0, 14'(addr));
      chk("valid", 14'h0, 14'(valid));
      @(posedge clk) rst_n <= 1'b1;
   endtask : test_reset
   task automatic test_phases();
      to_phase(0);
      for (int i = 0; i < 8; i++) begin
         chk("phases", 14'(1 << (i % 4)), 14'({p4, p3, p2, p1}));
         chk("clock out", 14'((i % 4) < 2), 14'(cko));
         @(negedge clk);
      end
   endtask : test_phases
   task automatic test_pipe();
      for (int i = 0; i < 3; i++) begin
         to_phase(1);
         if (i > 0) chk("pc step", 14'(last + 13'h1), 14'(addr));
         last = addr;
         chk("valid", 14'h1, 14'(valid));
         chk("ir", 14'h2000 | 14'(addr - 13'h1), ir);
         chk("read", 14'h1, 14'(rd));
         to_phase(3);
         chk("write", 14'h1, 14'(wr));
         chk("read off", 14'h0, 14'(rd));
      end
   endtask : test_pipe
   task automatic test_branch();
      to_phase(2);
      @(posedge clk);
      br <= 1'b1;
      tgt <= 13'h0155;
      @(posedge clk) br <= 1'b0;
      to_phase(1);
      chk("flush valid", 14'h0, 14'(valid));
      chk("flush ir", 14'h0, ir);
      chk("flush read", 14'h0, 14'(rd));
      to_phase(3);
      chk("flush write", 14'h0, 14'(wr));
      to_phase(1);
      chk("target valid", 14'h1, 14'(valid));
      chk("target ir", 14'h2155, ir);
      chk("target pc", 14'h0156, 14'(addr));
      chk("target read", 14'h1, 14'(rd));
   endtask : test_branch
   // phases freeze while the clock enable is low
   task automatic test_hold();
      to_phase(1);
      @(posedge clk) ce <= 1'b0;
      repeat (3) @(negedge clk);
      chk("held phase", 14'h4, 14'({p4, p3, p2, p1}));
      chk("held clock out", 14'h0, 14'(cko));
      @(posedge clk) ce <= 1'b1;
   endtask : test_hold
   task automatic print_verdict();
      if (errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   initial begin
      test_reset();
      test_phases();
      test_pipe();
      test_branch();
      test_hold();
      test_pipe();
      print_verdict();
   end
   // watchdog at 3000 cycles, well beyond the fewer than a hundred cycles the tests need
   initial begin
      #(3000 * 50);
      errors++;
      print_verdict();
   end
endmodule : quad_phase_fetch_execute_pipeline_test
`default_nettype wire
